// file: hdl/act_consts.svh
`ifndef ACT_CONSTS_SVH
`define ACT_CONSTS_SVH

// ==========================================================================
// Register map
`define ACT_ADDR_W 4
`define ACT_OFS_CORE0 4'h0
`define ACT_OFS_CORE1 4'h1
`define ACT_OFS_STATL 4'h2
`define ACT_OFS_STATH 4'h3
`define ACT_OFS_IRQST 4'h4
`define ACT_OFS_IRQMSK 4'h5
`define ACT_OFS_START 4'h6
`define ACT_OFS_RESULT 4'h8

// ==========================================================================
// Field layout of the core control register
`define ACT_CTL_MASK 16'h1F7F
`define ACT_EIS_HI 12
`define ACT_EIS_LO 10
`define ACT_RES_HI 9
`define ACT_RES_LO 8
`define ACT_DIV_HI 6
`define ACT_DIV_LO 0
`define ACT_CTL_RESET 16'h0000
`define ACT_STATH_MASK 16'h001F

// ==========================================================================
// Sizes and status bits
`define ACT_NUM_CH 21
`define ACT_CH_W 5
`define ACT_IRQ_EARLY0 0
`define ACT_IRQ_EARLY1 1
`define ACT_IRQ_DONE0 2
`define ACT_IRQ_DONE1 3
`define ACT_IRQ_W 4
`define ACT_TICK_W 8
`define ACT_CNT_W 5
`endif

// file: hdl/act_core_ctrl.sv
`timescale 1ns/100ps
`include "act_consts.svh"
module act_core_ctrl (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic [1:0] sampleValid,
  input wire logic [4:0] sampleCh0,
  input wire logic [4:0] sampleCh1,
  input wire logic [11:0] sampleData0,
  input wire logic [11:0] sampleData1,
  output logic [1:0] coreClkEn,
  output logic [1:0] earlyFlag,
  output logic irq
);
  act_res_if resBus();
  act_result_mem uMem(.mclk(mclk), .bus(resBus));

  // ========================================================================
  // Helpers
  function automatic logic [11:0] fit_result(input logic [11:0] raw, input logic [1:0] res);
    logic [11:0] v;
    v = 12'h000;
    case (res)
      2'h3: v = raw;
      2'h2: v = {2'h0, raw[11:2]};
      2'h1: v = {4'h0, raw[11:4]};
      default: v = {6'h0, raw[11:6]};
    endcase
    return v;
  endfunction : fit_result

  function automatic logic [4:0] conv_periods(input logic [1:0] res);
    logic [4:0] n;
    n = 5'h00;
    case (res)
      2'h3: n = 5'h0C;
      2'h2: n = 5'h0A;
      2'h1: n = 5'h08;
      default: n = 5'h06;
    endcase
    return n;
  endfunction : conv_periods

  // ========================================================================
  // Registers
  logic [15:0] ctl_reg [2];
  logic [20:0] ready_reg;
  logic [3:0] irqSt_reg;
  logic [3:0] irqMsk_reg;
  logic [1:0] start_reg;
  logic [20:0] rdClear;
  logic [3:0] irqSet;
  logic rdPend_reg;
  logic [15:0] rdMux_reg;
  logic [4:0] rdAddrLoad;
  logic isResult;

  // Only the one result offset opens the buffer window; the indices above it stay unmapped.
  assign isResult = (regAddr == `ACT_OFS_RESULT);
  assign rdAddrLoad = 5'(regWdata[4:0]);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_reg[0] <= `ACT_CTL_RESET;
      ctl_reg[1] <= `ACT_CTL_RESET;
    end else if (regWr && regAddr == `ACT_OFS_CORE0) begin
      ctl_reg[0] <= regWdata & `ACT_CTL_MASK;
    end else if (regWr && regAddr == `ACT_OFS_CORE1) begin
      ctl_reg[1] <= regWdata & `ACT_CTL_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irqMsk_reg <= 4'h0;
    end else if (regWr && regAddr == `ACT_OFS_IRQMSK) begin
      irqMsk_reg <= regWdata[3:0];
    end
  end

  // A write of a one to bit k of the start register begins a conversion on core k.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      start_reg <= 2'h0;
    end else begin
      start_reg <= (regWr && regAddr == `ACT_OFS_START) ? regWdata[1:0] : 2'h0;
    end
  end

  // ========================================================================
  // Result reads: a write of a channel number to the result offset selects the buffer.
  // A later read of that offset returns the selected buffer and clears its ready flag.
  logic [4:0] selCh_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      selCh_reg <= 5'h00;
    end else if (regWr && isResult) begin
      selCh_reg <= rdAddrLoad;
    end
  end

  // ========================================================================
  // Per core timing
  logic [1:0] storeReq;
  logic [11:0] storeData [2];
  logic [4:0] storeCh [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gCore
      act_pkg::act_state_t state_reg;
      logic [7:0] tick_reg;
      logic [4:0] left_reg;
      logic [7:0] divLim;
      logic [2:0] eis;
      logic [1:0] res;

      assign eis = ctl_reg[g][`ACT_EIS_HI:`ACT_EIS_LO];
      assign res = ctl_reg[g][`ACT_RES_HI:`ACT_RES_LO];
      // Divider codes 0 and 1 both give two source clocks.
      assign divLim = (ctl_reg[g][`ACT_DIV_HI:`ACT_DIV_LO] < 7'h02) ? 8'h02
          : {ctl_reg[g][`ACT_DIV_HI:`ACT_DIV_LO], 1'b0};

      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          tick_reg <= 8'h00;
        end else if (tick_reg >= divLim - 8'h01) begin
          tick_reg <= 8'h00;
        end else begin
          tick_reg <= tick_reg + 8'h01;
        end
      end
      assign coreClkEn[g] = (tick_reg >= divLim - 8'h01);

      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          state_reg <= act_pkg::ACT_IDLE;
          left_reg <= 5'h00;
          storeData[g] <= 12'h000;
          storeCh[g] <= 5'h00;
        end else begin
          case (state_reg)
            act_pkg::ACT_IDLE: begin
              if (start_reg[g]) begin
                left_reg <= conv_periods(res);
                state_reg <= act_pkg::ACT_CONV;
              end
            end
            act_pkg::ACT_CONV: begin
              if (sampleValid[g]) begin
                storeData[g] <= fit_result(g == 0 ? sampleData0 : sampleData1, res);
                storeCh[g] <= g == 0 ? sampleCh0 : sampleCh1;
              end
              if (coreClkEn[g]) begin
                left_reg <= left_reg - 5'h01;
                if (left_reg == 5'h01) begin
                  state_reg <= act_pkg::ACT_STORE;
                end
              end
            end
            act_pkg::ACT_STORE: begin
              state_reg <= act_pkg::ACT_IDLE;
            end
            default: begin
              state_reg <= act_pkg::ACT_IDLE;
            end
          endcase
        end
      end

      // Early flag: n+1 core periods before the data land in the buffer.
      assign earlyFlag[g] = (state_reg == act_pkg::ACT_CONV) && coreClkEn[g]
          && (left_reg == 5'({2'h0, eis}) + 5'h02);
      assign storeReq[g] = (state_reg == act_pkg::ACT_STORE);
    end
  endgenerate

  // Core 0 wins the buffer write when both finish at once; core 1 is retried a cycle later.
  logic pend1_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend1_reg <= 1'b0;
    end else begin
      pend1_reg <= storeReq[0] && (storeReq[1] || pend1_reg) ? 1'b1 : 1'b0;
    end
  end
  logic [1:0] doStore;
  assign doStore[0] = storeReq[0];
  assign doStore[1] = !storeReq[0] && (storeReq[1] || pend1_reg);

  assign resBus.wrEn = |doStore;
  assign resBus.wrAddr = doStore[0] ? storeCh[0] : storeCh[1];
  assign resBus.wrData = {4'h0, doStore[0] ? storeData[0] : storeData[1]};
  assign resBus.rdAddr = selCh_reg;

  // ========================================================================
  // Ready flags
  always_comb begin
    rdClear = '0;
    if (regRd && isResult && selCh_reg < 5'(`ACT_NUM_CH)) begin
      rdClear[selCh_reg] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ready_reg <= '0;
    end else begin
      for (int i = 0; i < `ACT_NUM_CH; i++) begin
        // A store in the same cycle as the clearing read keeps the flag set.
        if (resBus.wrEn && resBus.wrAddr == 5'(i)) begin
          ready_reg[i] <= 1'b1;
        end else if (rdClear[i]) begin
          ready_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // Interrupts
  assign irqSet = {doStore, earlyFlag};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irqSt_reg <= 4'h0;
    end else begin
      irqSt_reg <= irqSet | (irqSt_reg & ~((regWr && regAddr == `ACT_OFS_IRQST) ?
          regWdata[3:0] : 4'h0));
    end
  end
  assign irq = |(irqSt_reg & irqMsk_reg);

  // ========================================================================
  // Read port
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdPend_reg <= 1'b0;
      rdMux_reg <= 16'h0000;
    end else begin
      rdPend_reg <= regRd && isResult;
      case (regAddr)
        `ACT_OFS_CORE0: rdMux_reg <= ctl_reg[0];
        `ACT_OFS_CORE1: rdMux_reg <= ctl_reg[1];
        `ACT_OFS_STATL: rdMux_reg <= ready_reg[15:0];
        `ACT_OFS_STATH: rdMux_reg <= {11'h000, ready_reg[20:16]};
        `ACT_OFS_IRQST: rdMux_reg <= {12'h000, irqSt_reg};
        `ACT_OFS_IRQMSK: rdMux_reg <= {12'h000, irqMsk_reg};
        default: rdMux_reg <= 16'h0000;
      endcase
    end
  end
  assign regRdata = rdPend_reg ? resBus.rdData : rdMux_reg;

  // ========================================================================
  // Checks
  // Counting core ticks from the flag to the store checks the lead without reusing the
  // compare that raises the flag.
  logic [3:0] leadCnt_reg;
  logic leadArm_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      leadCnt_reg <= 4'h0;
      leadArm_reg <= 1'b0;
    end else if (earlyFlag[0]) begin
      leadCnt_reg <= 4'h0;
      leadArm_reg <= 1'b1;
    end else if (storeReq[0]) begin
      leadArm_reg <= 1'b0;
    end else if (coreClkEn[0] && leadArm_reg) begin
      leadCnt_reg <= leadCnt_reg + 4'h1;
    end
  end

  property p_early_lead;
    @(posedge mclk) disable iff (!rst_b)
    (storeReq[0] && leadArm_reg) |-> leadCnt_reg == {1'b0, gCore[0].eis} + 4'h1;
  endproperty
  a_early_lead: assert property (p_early_lead) else $error("early flag at wrong lead");

  property p_div_min;
    @(posedge mclk) disable iff (!rst_b)
    coreClkEn[0] |=> !coreClkEn[0];
  endproperty
  a_div_min: assert property (p_div_min) else $error("core clock faster than two");

  property p_ctl_unused;
    @(posedge mclk) disable iff (!rst_b)
    (ctl_reg[0] & ~`ACT_CTL_MASK) == 16'h0000 && (ctl_reg[1] & ~`ACT_CTL_MASK) == 16'h0000;
  endproperty
  a_ctl_unused: assert property (p_ctl_unused) else $error("unused control bit set");

  property p_ready_set;
    @(posedge mclk) disable iff (!rst_b)
    resBus.wrEn |=> ready_reg[$past(resBus.wrAddr)];
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

  property p_ready_clear;
    @(posedge mclk) disable iff (!rst_b)
    (rdClear[3] && !(resBus.wrEn && resBus.wrAddr == 5'h03)) |=> !ready_reg[3];
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready flag not cleared");

  property p_stath_zero;
    @(posedge mclk) disable iff (!rst_b)
    (regRd && regAddr == `ACT_OFS_STATH) |=> (regRdata & ~`ACT_STATH_MASK) == 16'h0000;
  endproperty
  a_stath_zero: assert property (p_stath_zero) else $error("status high upper bits set");

  property p_statl_map;
    @(posedge mclk) disable iff (!rst_b)
    (regRd && regAddr == `ACT_OFS_STATL) |=> regRdata == $past(ready_reg[15:0]);
  endproperty
  a_statl_map: assert property (p_statl_map) else $error("status low mismatch");

  property p_irq_level;
    @(posedge mclk) disable iff (!rst_b)
    earlyFlag[1] && irqMsk_reg[1] |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  c_early: cover property (@(posedge mclk) disable iff (!rst_b) earlyFlag[0]);
  c_store: cover property (@(posedge mclk) disable iff (!rst_b) resBus.wrEn);
  c_clear: cover property (@(posedge mclk) disable iff (!rst_b) |rdClear);
endmodule : act_core_ctrl

// file: hdl/act_if.sv
`timescale 1ns/100ps
interface act_res_if;
  logic wrEn;
  logic [4:0] wrAddr;
  logic [15:0] wrData;
  logic [4:0] rdAddr;
  logic [15:0] rdData;
  modport ctrl(output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem(input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : act_res_if

// file: hdl/act_pkg.sv
package act_pkg;
  typedef enum logic [2:0] {
    ACT_IDLE = 3'h1,
    ACT_CONV = 3'h2,
    ACT_STORE = 3'h4
  } act_state_t;
endpackage : act_pkg

// file: hdl/act_result_mem.sv
`timescale 1ns/100ps
module act_result_mem (
  input wire logic mclk,
  act_res_if.mem bus
);
  logic [15:0] store [0:20];

  // Result buffers, one per analog input; read data come from a register.
  always_ff @(posedge mclk) begin
    if (bus.wrEn) begin
      store[bus.wrAddr] <= bus.wrData;
    end
  end

  always_ff @(posedge mclk) begin
    bus.rdData <= store[bus.rdAddr];
  end
endmodule : act_result_mem

// file: tb/act_conv_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Conversion core stand-in
module act_conv_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic [4:0] ch,
  input wire logic [11:0] val,
  output logic [1:0] sampleValid,
  output logic [4:0] sampleCh0,
  output logic [4:0] sampleCh1,
  output logic [11:0] sampleData0,
  output logic [11:0] sampleData1
);
  logic phaseReg;

  // In slow mode a sample is offered only every other cycle.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phaseReg <= 1'b0;
    end else begin
      phaseReg <= ~phaseReg;
    end
  end

  // Off-valid cycles show inverted data, so a stale sample never passes for a fresh one.
  always_comb begin
    sampleValid = {2{rst_b & (~slow | phaseReg)}};
    sampleCh0 = sampleValid[0] ? ch : ~ch;
    sampleCh1 = sampleValid[1] ? ch : ~ch;
    sampleData0 = sampleValid[0] ? val : ~val;
    sampleData1 = sampleValid[1] ? val : ~val;
  end
endmodule : act_conv_model

// file: tb/adc_core_timing_ready_flags_test.sv
`timescale 1ns/100ps
module adc_core_timing_ready_flags_test;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  logic [1:0] sampleValid;
  logic [4:0] sampleCh0;
  logic [4:0] sampleCh1;
  logic [11:0] sampleData0;
  logic [11:0] sampleData1;
  logic [1:0] coreClkEn;
  logic [1:0] earlyFlag;
  logic irq;
  logic slow = 1'b0;
  logic [4:0] ch = 5'h00;
  logic [11:0] val = 12'h000;
  logic [15:0] rnd;
  logic rdSeen = 1'b0;
  logic [15:0] expQ[$];
  int err_total = 0;
  int tests_run = 0;
  int regs[8] = '{0, 1, 2, 3, 4, 5, 7, 15};
  int divs[4] = '{0, 1, 2, 127};

  always #25 mclk = ~mclk;

  act_core_ctrl uut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sampleValid(sampleValid),
    .sampleCh0(sampleCh0), .sampleCh1(sampleCh1), .sampleData0(sampleData0),
    .sampleData1(sampleData1), .coreClkEn(coreClkEn), .earlyFlag(earlyFlag), .irq(irq));

  act_conv_model model (.mclk(mclk), .rst_b(rst_b), .slow(slow), .ch(ch), .val(val),
    .sampleValid(sampleValid), .sampleCh0(sampleCh0), .sampleCh1(sampleCh1),
    .sampleData0(sampleData0), .sampleData1(sampleData1));

  // ==========================================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // Result read data stand only in the cycle after the strobe, so every read is taken there.
  always @(posedge mclk) begin
    if (rdSeen) begin
      check(regRdata, expQ.pop_front());
    end
    rdSeen = regRd;
  end

  initial begin
    #2000000;
    err_total++;
    $display("watchdog expired");
    stop_test();
  end

  // ==========================================================================
  // Bus and timing tasks
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(exp);
    @(posedge mclk);
    regRd <= 1'b0;
  endtask : rd

  task automatic wait_tick(input int k, output int t);
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (coreClkEn[k] !== 1'b1 && t < 600);
  endtask : wait_tick

  task automatic conv(input int k, input int res, input int lead);
    int t;
    int n;
    ch <= 5'($urandom % 21);
    val <= 12'($urandom);
    slow <= 1'($urandom);
    wr(4'h5, 16'h0001 << (2 + k));
    wr(4'(k), 16'((lead << 10) | (res << 8) | 5));
    wr(4'h6, 16'h0001 << k);
    t = 0;
    n = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (earlyFlag[k] !== 1'b1 && t < 3000);
    do begin
      @(posedge mclk);
      t++;
      n += int'(coreClkEn[k] === 1'b1);
    end while (irq !== 1'b1 && t < 3000);
    check(16'(n), 16'(lead + 1));
    rd(4'h2, ch < 16 ? 16'h0001 << ch : 16'h0000);
    rd(4'h3, ch >= 16 ? 16'h0001 << (ch - 16) : 16'h0000);
    wr(4'h5, 16'h0000);
    rd(4'h4, 16'(5 << k));
    check({15'h0000, irq}, 16'h0000);
    wr(4'h4, 16'h000F);
    wr(4'h5, 16'h000F);
    rd(4'h4, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    wr(4'h8, 16'(ch));
    rd(4'h8, 16'(val >> (6 - 2 * res)));
    rd(4'h2, 16'h0000);
    rd(4'h3, 16'h0000);
    $display("conversion core %0d res %0d lead %0d done", k, res, lead);
  endtask : conv

  // ==========================================================================
  // Main sequence
  initial begin
    int t;
    void'($urandom(32'h7F54));
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (regs[i]) begin
      rd(4'(regs[i]), 16'h0000);
    end
    $display("reset values done");
    rnd = 16'($urandom);
    wr(4'h0, 16'hFFFF);
    wr(4'h1, rnd);
    wr(4'h2, 16'hFFFF);
    wr(4'h3, 16'hFFFF);
    wr(4'hF, 16'hFFFF);
    rd(4'h0, 16'h1F7F);
    rd(4'h1, rnd & 16'h1F7F);
    rd(4'h2, 16'h0000);
    rd(4'h3, 16'h0000);
    rd(4'hF, 16'h0000);
    $display("register access done");
    foreach (divs[i]) begin
      wr(4'h0, 16'(divs[i]));
      wait_tick(0, t);
      wait_tick(0, t);
      check(16'(t), 16'(2 * (divs[i] < 2 ? 1 : divs[i])));
    end
    $display("divider done");
    for (int l = 0; l < 8; l++) begin
      conv(0, 3, l);
    end
    conv(1, 2, $urandom % 8);
    conv(1, 1, $urandom % 6);
    conv(1, 0, $urandom % 4);
    conv(0, 0, $urandom % 4);
    repeat (4) @(posedge mclk);
    stop_test();
  end
endmodule : adc_core_timing_ready_flags_test
